// >>> design/arcpc_top.sv
// Purpose: Result registers, result FIFO, compare values and pin release over APB.
// Assumes: Engine pulses conv_done_i with the new result; software is the only bus master.
// Notes:   One wait state on every APB access; prdata comes from a flop.
//
// Design decision made here: the APB interface to the registers.
module arcpc_top #(
   parameter int unsigned FIFO_N = arcpc_pkg::FIFO_N
) (
   input  wire logic                           sys_clk_i,
   input  wire logic                           rst_b_i,
   input  wire logic                           psel_i,
   input  wire logic                           penable_i,
   input  wire logic                           pwrite_i,
   input  wire logic [arcpc_pkg::APB_AW-1:0]   paddr_i,
   input  wire logic [arcpc_pkg::APB_DW-1:0]   pwdata_i,
   input  wire logic [3:0]                     pstrb_i,
   output logic      [arcpc_pkg::APB_DW-1:0]   prdata_o,
   output logic                                pready_o,
   output logic                                pslverr_o,
   input  wire logic                           conv_done_i,
   input  wire logic [arcpc_pkg::RES_W-1:0]    conv_data_i,
   output logic                                conv_complete_o,
   output logic                                res_12_o,
   output logic                                compare_enable_o,
   output logic [arcpc_pkg::CTRL_DEP_W-1:0]    fifo_depth_o,
   input  wire logic [arcpc_pkg::PIN_N-1:0]    port_out_i,
   input  wire logic [arcpc_pkg::PIN_N-1:0]    port_oe_b_i,
   input  wire logic [arcpc_pkg::PIN_N-1:0]    port_pull_i,
   input  wire logic [arcpc_pkg::PIN_N-1:0]    pad_in_i,
   output logic      [arcpc_pkg::PIN_N-1:0]    pad_out_o,
   output logic      [arcpc_pkg::PIN_N-1:0]    pad_oe_b_o,
   output logic      [arcpc_pkg::PIN_N-1:0]    pad_pull_o,
   output logic      [arcpc_pkg::PIN_N-1:0]    port_in_o
);
   import arcpc_pkg::*;

   typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_DONE} arcpc_bus_t;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Magnitude compare: in 12-bit mode the whole result against the high value's low nibble joined above the low value; 8-bit mode compares the low byte only
   function automatic logic cmp_match(input logic [RES_W-1:0] res,
                                      input logic [7:0]       cvh,
                                      input logic [7:0]       cvl,
                                      input logic             res12,
                                      input logic             ge);
      logic [RES_W-1:0] ref_v;
      logic [RES_W-1:0] val_v;
      ref_v = res12 ? {cvh[3:0], cvl} : {4'h0, cvl};
      val_v = res12 ? res : {4'h0, res[7:0]};
      cmp_match = ge ? (val_v >= ref_v) : (val_v < ref_v);
   endfunction

   function automatic logic idx_hit(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] b);
      idx_hit = (a == b);
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   arcpc_bus_t             bus_r;
   arcpc_bus_t             bus_nxt;
   logic [7:0]             ctrl_r;
   logic [7:0]             cvh_r;
   logic [7:0]             cvl_r;
   logic [7:0]             pin_lo_r;
   logic [7:0]             pin_hi_r;
   logic [RES_W-1:0]       mem_r [FIFO_N];
   logic [PTR_W-1:0]       wr_ptr_r;
   logic [PTR_W-1:0]       rd_ptr_r;
   logic [CNT_W-1:0]       cnt_r;
   logic [CNT_W-1:0]       cnt_nxt;
   logic                   lock_r;
   logic                   ready_r;
   logic                   complete_r;
   logic [APB_DW-1:0]      prdata_r;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire [IDX_W-1:0] idx_w    = paddr_i[APB_AW-1:2];
   wire hit_rh_w             = idx_hit(idx_w, IDX_RES_HIGH);
   wire hit_rl_w             = idx_hit(idx_w, IDX_RES_LOW);
   wire hit_cvh_w            = idx_hit(idx_w, IDX_CV_HIGH);
   wire hit_cvl_w            = idx_hit(idx_w, IDX_CV_LOW);
   wire hit_ctrl_w           = idx_hit(idx_w, IDX_CTRL);
   wire hit_stat_w           = idx_hit(idx_w, IDX_STATUS);
   wire hit_plo_w            = idx_hit(idx_w, IDX_PIN_LOW);
   wire hit_phi_w            = idx_hit(idx_w, IDX_PIN_HIGH);
   wire mapped_w             = hit_rh_w | hit_rl_w | hit_cvh_w | hit_cvl_w | hit_ctrl_w
                               | hit_stat_w | hit_plo_w | hit_phi_w;
   wire acc_fin_w            = psel_i & penable_i & (bus_r == BUS_DONE);
   wire wr_fin_w             = acc_fin_w & pwrite_i & pstrb_i[0];
   wire rd_fin_w             = acc_fin_w & ~pwrite_i;
   wire fetch_w              = psel_i & penable_i & (bus_r == BUS_IDLE);

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   wire                  res12_w   = ctrl_r[CTRL_RES12_BIT];
   wire                  cmp_en_w  = ctrl_r[CTRL_CMPEN_BIT];
   wire                  cmp_ge_w  = ctrl_r[CTRL_CMPGE_BIT];
   wire [CTRL_DEP_W-1:0] depth_w   = ctrl_r[CTRL_DEP_LSB +: CTRL_DEP_W];
   wire                  fifo_en_w = (depth_w != 3'h0);
   wire [CNT_W-1:0]      levels_w  = {1'b0, depth_w} + 4'h1;
   wire                  mode_chg_w = wr_fin_w & hit_ctrl_w & (pwdata_i[CTRL_RES12_BIT] != res12_w);
   wire                  dep_chg_w  = wr_fin_w & hit_ctrl_w
                                      & (pwdata_i[CTRL_DEP_LSB +: CTRL_DEP_W] != depth_w);
   wire                  flush_w    = mode_chg_w | dep_chg_w;

   // ------------------------------------------------------------
   // Result path
   // ------------------------------------------------------------
   // A high read in flight in 12-bit resolution blocks too, so the low byte captured later is never torn
   wire rh_hold_w  = psel_i & penable_i & ~pwrite_i & hit_rh_w & res12_w;
   wire blocked_w  = lock_r | rh_hold_w;
   wire cmp_ok_w   = ~cmp_en_w | cmp_match(conv_data_i, cvh_r, cvl_r, res12_w, cmp_ge_w);
   wire room_w     = ~fifo_en_w | (cnt_r < levels_w);
   wire push_w     = conv_done_i & cmp_ok_w & ~blocked_w & ~flush_w & room_w;
   wire pop_w      = rd_fin_w & hit_rl_w & fifo_en_w & (cnt_r != 4'h0);
   wire [PTR_W-1:0] widx_w = fifo_en_w ? wr_ptr_r : 3'h0;
   wire [PTR_W-1:0] ridx_w = fifo_en_w ? rd_ptr_r : 3'h0;
   wire [RES_W-1:0] head_w = mem_r[ridx_w];
   wire [RES_W-1:0] store_w = res12_w ? conv_data_i : {4'h0, conv_data_i[7:0]};
   wire xfer_w     = push_w & (~fifo_en_w | (cnt_nxt == levels_w));

   always_comb begin
      cnt_nxt = cnt_r;
      if (flush_w) begin
         cnt_nxt = 4'h0;
      end else if (!fifo_en_w) begin
         cnt_nxt = push_w ? 4'h1 : cnt_r;
      end else begin
         cnt_nxt = cnt_r + {3'h0, push_w} - {3'h0, pop_w};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || flush_w) begin
         for (int i = 0; i < FIFO_N; i++) begin
            mem_r[i] <= 12'h000;
         end
      end else if (push_w) begin
         mem_r[widx_w] <= store_w;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || flush_w) begin
         wr_ptr_r <= 3'h0;
         rd_ptr_r <= 3'h0;
         cnt_r    <= 4'h0;
      end else begin
         wr_ptr_r <= (push_w && fifo_en_w) ? wr_ptr_r + 3'h1 : wr_ptr_r;
         rd_ptr_r <= pop_w ? rd_ptr_r + 3'h1 : rd_ptr_r;
         cnt_r    <= cnt_nxt;
      end
   end

   // Interlock exists only in 12-bit resolution; the low read always releases it
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || flush_w) begin
         lock_r <= 1'b0;
      end else if (rd_fin_w && hit_rh_w && res12_w) begin
         lock_r <= 1'b1;
      end else if (rd_fin_w && hit_rl_w) begin
         lock_r <= 1'b0;
      end
   end

   // Ready is set by a transfer and cleared by a low read; the set wins
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || flush_w) begin
         ready_r <= 1'b0;
      end else if (xfer_w) begin
         ready_r <= 1'b1;
      end else if (rd_fin_w && hit_rl_w) begin
         ready_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         complete_r <= 1'b0;
      end else begin
         complete_r <= xfer_w;
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         ctrl_r   <= CTRL_RST;
         cvh_r    <= CV_RST;
         cvl_r    <= CV_RST;
         pin_lo_r <= PIN_RST;
         pin_hi_r <= PIN_RST;
      end else if (wr_fin_w) begin
         if (hit_ctrl_w) ctrl_r   <= pwdata_i[7:0] & 8'h77;
         if (hit_cvh_w)  cvh_r    <= pwdata_i[7:0];
         if (hit_cvl_w)  cvl_r    <= pwdata_i[7:0];
         if (hit_plo_w)  pin_lo_r <= pwdata_i[7:0];
         if (hit_phi_w)  pin_hi_r <= pwdata_i[7:0];
      end
   end

   // ------------------------------------------------------------
   // APB sequencing and read data
   // ------------------------------------------------------------
   always_comb begin
      case (bus_r)
         BUS_IDLE:  bus_nxt = fetch_w ? BUS_DONE : BUS_IDLE;
         BUS_DONE:  bus_nxt = BUS_IDLE;
         default:   bus_nxt = BUS_IDLE;
      endcase
   end

   wire [7:0] stat_w = {cnt_r, 2'b00, lock_r, ready_r};
   wire [7:0] rsel_w = hit_rh_w   ? {4'h0, head_w[11:8]} :
                       hit_rl_w   ? head_w[7:0] :
                       hit_cvh_w  ? cvh_r :
                       hit_cvl_w  ? cvl_r :
                       hit_ctrl_w ? ctrl_r :
                       hit_stat_w ? stat_w :
                       hit_plo_w  ? pin_lo_r :
                       hit_phi_w  ? pin_hi_r : 8'h00;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         bus_r    <= BUS_IDLE;
         prdata_r <= 32'h0000_0000;
      end else begin
         bus_r    <= bus_nxt;
         prdata_r <= (fetch_w && !pwrite_i) ? {24'h00_0000, rsel_w} : prdata_r;
      end
   end

   assign prdata_o         = prdata_r;
   assign pready_o         = psel_i & penable_i & (bus_r == BUS_DONE);
   assign pslverr_o        = pready_o & ~mapped_w;
   assign conv_complete_o  = complete_r;
   assign res_12_o         = res12_w;
   assign compare_enable_o = cmp_en_w;
   assign fifo_depth_o     = depth_w;

   // ------------------------------------------------------------
   // Pin release
   // ------------------------------------------------------------
   wire [PIN_N-1:0] release_w = {pin_hi_r, pin_lo_r};

   arcpc_pin_gate #(.N(PIN_N)) u_pin_gate (
      .release_i   (release_w),
      .port_out_i  (port_out_i),
      .port_oe_b_i (port_oe_b_i),
      .port_pull_i (port_pull_i),
      .pad_in_i    (pad_in_i),
      .pad_out_o   (pad_out_o),
      .pad_oe_b_o  (pad_oe_b_o),
      .pad_pull_o  (pad_pull_o),
      .port_in_o   (port_in_o)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_low_byte_load: assert property (push_w && !fifo_en_w |=> head_w[7:0] == $past(conv_data_i[7:0]))
      else $error("low result byte not loaded");
   chk_cmp_false_keep: assert property (conv_done_i && cmp_en_w && !cmp_ok_w && !fifo_en_w && !flush_w
                                        |=> $stable(head_w))
      else $error("result changed on failed compare");
   chk_lock_discard: assert property (blocked_w && conv_done_i && !fifo_en_w && !flush_w
                                      |=> $stable(head_w) && !conv_complete_o)
      else $error("blocked result was transferred");
   chk_lock_mode_only: assert property ($rose(lock_r) |-> $past(res12_w))
      else $error("interlock set in 8-bit resolution");
   chk_mode_flush: assert property (mode_chg_w |=> cnt_r == 4'h0 && !ready_r && head_w == 12'h000)
      else $error("resolution change kept stale result");
   chk_fifo_pop_order: assert property (pop_w |=> rd_ptr_r == $past(rd_ptr_r) + 3'h1)
      else $error("fifo read pointer did not advance");
   chk_fifo_complete: assert property (push_w && fifo_en_w && !xfer_w |=> !conv_complete_o)
      else $error("complete before fifo filled");
   chk_fill_level: assert property (xfer_w && fifo_en_w |=> cnt_r == $past(levels_w) && conv_complete_o)
      else $error("complete with wrong fill level");
   chk_cmp_value: assert property (conv_done_i && cmp_en_w && res12_w && !cmp_ge_w && !blocked_w
                                   && !fifo_en_w && !flush_w && (conv_data_i < {cvh_r[3:0], cvl_r})
                                   |=> ready_r ##0 head_w == $past(conv_data_i))
      else $error("matching compare not transferred");
   chk_cmp_off_pass: assert property (conv_done_i && !cmp_en_w && !blocked_w && !fifo_en_w && !flush_w
                                      |=> ready_r)
      else $error("transfer lost with compare off");
   chk_pin_map: assert property (pad_oe_b_o[9] == (port_oe_b_i[9] | pin_hi_r[1])
                                 && port_in_o[3] == (pad_in_i[3] & ~pin_lo_r[3]))
      else $error("pin release bit mapped wrongly");
   chk_release_float: assert property (((pad_oe_b_o & release_w) == release_w)
                                       && ((port_in_o | pad_pull_o) & release_w) == 16'h0000)
      else $error("released pin still under port control");
   chk_pin_pass: assert property (((pad_oe_b_o ^ port_oe_b_i) & ~release_w) == 16'h0000
                                  && ((pad_out_o ^ port_out_i) & ~release_w) == 16'h0000
                                  && ((port_in_o ^ pad_in_i) & ~release_w) == 16'h0000)
      else $error("kept pin lost port control");

   cov_blocked_drop: cover property (lock_r && conv_done_i);
   cov_fifo_full:    cover property (xfer_w && fifo_en_w);
   cov_mode_change:  cover property (mode_chg_w);
   cov_unmapped:     cover property (pslverr_o);
endmodule

// >>> design/arcpc_pkg.sv
// Purpose: Constants for the converter result, compare and pin-release block.
// Assumes: APB word addressing, index times four gives the byte address.
// Notes:   Rules carried by this block follow.
package arcpc_pkg;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int unsigned APB_AW   = 16;
   localparam int unsigned APB_DW   = 32;
   localparam int unsigned IDX_W    = 14;
   localparam int unsigned RES_W    = 12;
   localparam int unsigned FIFO_N   = 8;
   localparam int unsigned PTR_W    = 3;
   localparam int unsigned CNT_W    = 4;
   localparam int unsigned PIN_N    = 16;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_RES_HIGH = 14'h0014;
   localparam logic [IDX_W-1:0] IDX_RES_LOW  = 14'h0015;
   localparam logic [IDX_W-1:0] IDX_CV_HIGH  = 14'h0016;
   localparam logic [IDX_W-1:0] IDX_CV_LOW   = 14'h0017;
   localparam logic [IDX_W-1:0] IDX_CTRL     = 14'h0018;
   localparam logic [IDX_W-1:0] IDX_STATUS   = 14'h0019;
   localparam logic [IDX_W-1:0] IDX_PIN_LOW  = 14'h30AC;
   localparam logic [IDX_W-1:0] IDX_PIN_HIGH = 14'h30AD;
   // ------------------------------------------------------------
   // Fields
   // ------------------------------------------------------------
   localparam int unsigned CTRL_RES12_BIT = 0;
   localparam int unsigned CTRL_CMPEN_BIT = 1;
   localparam int unsigned CTRL_CMPGE_BIT = 2;
   localparam int unsigned CTRL_DEP_LSB   = 4;
   localparam int unsigned CTRL_DEP_W     = 3;
   localparam int unsigned STAT_READY_BIT = 0;
   localparam int unsigned STAT_LOCK_BIT  = 1;
   localparam int unsigned STAT_CNT_LSB   = 4;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CV_RST   = 8'h00;
   localparam logic [7:0] PIN_RST  = 8'h00;
endpackage

// >>> design/arcpc_pin_gate.sv
// Purpose: Removes port control from pins released to the converter.
// Assumes: Output enables are active low; high means the pad is not driven.
// Notes:   Pure gating, no state.
module arcpc_pin_gate #(
   parameter int unsigned N = arcpc_pkg::PIN_N
) (
   input  wire logic [N-1:0] release_i,
   input  wire logic [N-1:0] port_out_i,
   input  wire logic [N-1:0] port_oe_b_i,
   input  wire logic [N-1:0] port_pull_i,
   input  wire logic [N-1:0] pad_in_i,
   output logic      [N-1:0] pad_out_o,
   output logic      [N-1:0] pad_oe_b_o,
   output logic      [N-1:0] pad_pull_o,
   output logic      [N-1:0] port_in_o
);
   // Released pins float, read back zero and lose their pullup
   assign pad_oe_b_o = port_oe_b_i | release_i;
   assign pad_out_o  = port_out_i & ~release_i;
   assign pad_pull_o = port_pull_i & ~release_i;
   assign port_in_o  = pad_in_i & ~release_i;
endmodule

// >>> dv/arcpc_top_tb.sv
// Purpose: Self-checking bench for the result, compare and pin-release block.
// Assumes: Design answers APB in its own time; results arrive as conv_done_i pulses.
// Notes:   Only pstrb_i is tied; every check counts, mismatches print one line.
module arcpc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import arcpc_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic                sys_clk;
   logic                rst_b;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [APB_AW-1:0]   paddr;
   logic [APB_DW-1:0]   pwdata;
   logic                conv_done;
   logic [RES_W-1:0]    conv_data;
   logic [PIN_N-1:0]    port_out, port_oe_b, port_pull, pad_in;
   logic [APB_DW-1:0]   prdata_o;
   logic                pready_o, pslverr_o, conv_complete_o, res_12_o, compare_enable_o;
   logic [CTRL_DEP_W-1:0] fifo_depth_o;
   logic [PIN_N-1:0]    pad_out_o, pad_oe_b_o, pad_pull_o, port_in_o;
   logic [31:0]         rdat;
   logic                rerr;
   int                  num_errors = 0;
   int                  checked = 0;
   arcpc_top #(.FIFO_N(FIFO_N)) dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_done_i(conv_done), .conv_data_i(conv_data),
      .conv_complete_o(conv_complete_o), .res_12_o(res_12_o), .compare_enable_o(compare_enable_o),
      .fifo_depth_o(fifo_depth_o), .port_out_i(port_out), .port_oe_b_i(port_oe_b), .port_pull_i(port_pull),
      .pad_in_i(pad_in), .pad_out_o(pad_out_o), .pad_oe_b_o(pad_oe_b_o), .pad_pull_o(pad_pull_o),
      .port_in_o(port_in_o));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Request stands until pready is seen at a rising edge; data and error are taken at that edge
   task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready_o !== 1'b1);
      rdat = prdata_o;
      rerr = pslverr_o;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input string what, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      check(what, rdat, exp);
   endtask
   task automatic conv(input logic [RES_W-1:0] d, input logic exp_done);
      @(posedge sys_clk);
      conv_done <= 1'b1;
      conv_data <= d;
      @(posedge sys_clk);
      conv_done <= 1'b0;
      @(negedge sys_clk);
      check("conv_complete_o", 32'(conv_complete_o), 32'(exp_done));
   endtask
   // ------------------------------------------------------------
   // Clock, reset and watchdog
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      num_errors++;
      complete_run();
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      logic [IDX_W-1:0] rw_idx [5];
      logic [11:0]      fifo_vals [3];
      rw_idx = '{IDX_CV_HIGH, IDX_CV_LOW, IDX_CTRL, IDX_PIN_LOW, IDX_PIN_HIGH};
      fifo_vals = '{12'h111, 12'h222, 12'h333};
      {psel, penable, pwrite, paddr, pwdata, conv_done, conv_data} = '0;
      port_out = 16'hFFFF;
      port_oe_b = 16'h0000;
      port_pull = 16'hFFFF;
      pad_in = 16'hFFFF;
      rst_b = 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      foreach (rw_idx[i]) rd("reset value", rw_idx[i], 32'h0000_0000);
      check("pad_oe_b_o", 32'(pad_oe_b_o), 32'h0000_0000);
      apb(1'b0, 14'h0100, 32'h0);
      check("unmapped error", 32'(rerr), 32'h1);
      check("unmapped data", rdat, 32'h0);
      // Channels 0, 7 and 9 released; the rest keep port control
      apb(1'b1, IDX_PIN_LOW, 32'h0000_0081);
      apb(1'b1, IDX_PIN_HIGH, 32'h0000_0002);
      rd("analog_pin_select_low", IDX_PIN_LOW, 32'h0000_0081);
      rd("analog_pin_select_high", IDX_PIN_HIGH, 32'h0000_0002);
      check("pad_oe_b_o", 32'(pad_oe_b_o), 32'h0000_0281);
      check("pad_out_o", 32'(pad_out_o), 32'h0000_FD7E);
      check("pad_pull_o", 32'(pad_pull_o), 32'h0000_FD7E);
      check("port_in_o", 32'(port_in_o), 32'h0000_FD7E);
      apb(1'b1, IDX_CTRL, 32'h0000_0001);
      conv(12'hABC, 1'b1);
      apb(1'b1, IDX_RES_LOW, 32'h0000_0011);
      rd("result_high", IDX_RES_HIGH, 32'h0000_000A);
      conv(12'h123, 1'b0);
      rd("result_low", IDX_RES_LOW, 32'h0000_00BC);
      conv(12'h456, 1'b1);
      rd("result_low", IDX_RES_LOW, 32'h0000_0056);
      // Compare passes when the result is below 0x580
      apb(1'b1, IDX_CV_HIGH, 32'h0000_0005);
      apb(1'b1, IDX_CV_LOW, 32'h0000_0080);
      apb(1'b1, IDX_CTRL, 32'h0000_0003);
      @(negedge sys_clk);
      check("compare_enable_o", 32'(compare_enable_o), 32'h1);
      conv(12'h57F, 1'b1);
      conv(12'h580, 1'b0);
      conv(12'h67F, 1'b0);
      rd("result_high", IDX_RES_HIGH, 32'h0000_0005);
      rd("result_low", IDX_RES_LOW, 32'h0000_007F);
      // Greater-or-equal relation: only results at or above 0x580 pass
      apb(1'b1, IDX_CTRL, 32'h0000_0007);
      conv(12'h57F, 1'b0);
      conv(12'h580, 1'b1);
      rd("result_low", IDX_RES_LOW, 32'h0000_0080);
      apb(1'b1, IDX_CTRL, 32'h0000_0000);
      rd("result_low", IDX_RES_LOW, 32'h0000_0000);
      rd("result_high", IDX_RES_HIGH, 32'h0000_0000);
      conv(12'h0DE, 1'b1);
      rd("result_low", IDX_RES_LOW, 32'h0000_00DE);
      // Depth code 2 means three levels
      apb(1'b1, IDX_CTRL, 32'h0000_0021);
      @(negedge sys_clk);
      check("fifo_depth_o", 32'(fifo_depth_o), 32'h2);
      check("res_12_o", 32'(res_12_o), 32'h1);
      conv(fifo_vals[0], 1'b0);
      conv(fifo_vals[1], 1'b0);
      conv(fifo_vals[2], 1'b1);
      rd("status", IDX_STATUS, 32'h0000_0031);
      foreach (fifo_vals[i]) begin
         rd("fifo high", IDX_RES_HIGH, {28'h0, fifo_vals[i][11:8]});
         rd("fifo low", IDX_RES_LOW, {24'h0, fifo_vals[i][7:0]});
      end
      complete_run();
   end
endmodule
